// >>> ddfe_map.svh
// Constants of the dual-channel DDR byte front end: framing, FIFO, serial port, timing.
// Assumes inclusion by bare name from the package only.
`ifndef DDFE_MAP_SVH
`define DDFE_MAP_SVH

`define DDFE_LAST_BYTE      2'h3
`define DDFE_FIFO_DEPTH     8
`define DDFE_FIFO_AW        3
`define DDFE_FIFO_FULL      4'h8
`define DDFE_CONV_DIV_LAST  1'h1

`define DDFE_SER_BITS       5'h10
`define DDFE_SER_LAST       5'h0f
`define DDFE_SER_INSTR      5'h08
`define DDFE_SER_INSTR_LAST 5'h07

`define DDFE_REG_CFG        7'h00
`define DDFE_REG_STAT       7'h01
`define DDFE_CFG_FOUR_WIRE  0
`define DDFE_CFG_REVERSE    1
`define DDFE_CFG_EXTREF     2
`define DDFE_CFG_RESET      8'h00
`define DDFE_STAT_ALARM     7

`define DDFE_CLK_PERIOD_NS  20
`define DDFE_SCLK_PERIOD_NS 100
`define DDFE_SCLK_HALF_CYC  ((`DDFE_SCLK_PERIOD_NS / 2) / `DDFE_CLK_PERIOD_NS)

`endif

// >>> ddfe_pkg.sv
// Types of the dual-channel DDR byte front end: state records of both ends.
// Assumes ddfe_map.svh on the include path.
`include "ddfe_map.svh"

package ddfe_pkg;

  typedef logic [7:0] ddfe_byte_t;

  typedef struct packed {
    logic                                dclk_prev;
    logic                                cclk_prev;
    logic                                sclk_prev;
    logic                                aligned;
    logic [1:0]                          byte_idx;
    logic [23:0]                         frag;
    logic [`DDFE_FIFO_DEPTH-1:0][31:0]   mem;
    logic [`DDFE_FIFO_AW-1:0]            wr_ptr;
    logic [`DDFE_FIFO_AW-1:0]            rd_ptr;
    logic [`DDFE_FIFO_AW:0]              count;
    logic                                div;
    logic [15:0]                         out_a;
    logic [15:0]                         out_b;
    logic                                out_valid;
    ddfe_byte_t                          cfg;
    logic                                alarm;
    logic [4:0]                          ser_cnt;
    logic [14:0]                         ser_in;
    logic                                ser_rd;
    ddfe_byte_t                          ser_out;
    logic                                sdo;
    logic                                sdo_en;
  } ddfe_dev_state_t;

  typedef struct packed {
    logic        dclk;
    ddfe_byte_t  bus;
    logic        frame;
    logic        sending;
    logic [1:0]  byte_idx;
    logic [23:0] rest;
    logic        txen;
    logic        rstn;
    logic        ser_busy;
    logic [2:0]  half;
    logic [4:0]  ser_bit;
    logic        sclk;
    logic        sen_n;
    logic        sout;
    logic        soe;
    logic [15:0] ser_sh;
    logic        ser_rd;
    ddfe_byte_t  rdata;
    logic        done;
  } ddfe_src_state_t;

endpackage : ddfe_pkg

// >>> ddfe_link_if.sv
// Link between the data source and the converter front end: DDR byte bus, strobes,
// control pins and the serial control port. Assumes both ends run on one common clock.
`timescale 1ns/10ps
`default_nettype none

interface ddfe_link_if;
  logic       data_clock;
  logic [7:0] data_bus;
  logic       frame_strobe;
  logic       transmit_enable;
  logic       chip_reset_n;
  logic       serial_enable_n;
  logic       serial_clock;
  logic       sdio_dev_out;
  logic       sdio_dev_oe;
  logic       sdio_src_out;
  logic       sdio_src_oe;
  logic       serial_data_io;
  logic       alarm_serial_out;

  // Shared data wire; weak pull-down when neither end drives
  assign serial_data_io = sdio_dev_oe ? sdio_dev_out : (sdio_src_oe ? sdio_src_out : 1'b0);

  modport device (
    input  data_clock, data_bus, frame_strobe, transmit_enable, chip_reset_n,
    input  serial_enable_n, serial_clock, serial_data_io,
    output sdio_dev_out, sdio_dev_oe, alarm_serial_out
  );

  modport source (
    output data_clock, data_bus, frame_strobe, transmit_enable, chip_reset_n,
    output serial_enable_n, serial_clock, sdio_src_out, sdio_src_oe,
    input  serial_data_io, alarm_serial_out
  );
endinterface : ddfe_link_if

`default_nettype wire

// >>> ddfe_source.sv
// Data source end: sends sample pairs as DDR bytes with a frame strobe, drives the
// control pins and runs the serial control port as master. Assumes one common clock.
`timescale 1ns/10ps
`default_nettype none

module ddfe_source (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        CE,
  ddfe_link_if.source      LINK,
  input  wire logic [15:0] SAMPLE_A,
  input  wire logic [15:0] SAMPLE_B,
  input  wire logic        SAMPLE_VALID,
  output logic             SAMPLE_READY,
  input  wire logic        TX_ENABLE,
  input  wire logic        CHIP_RESET_N,
  input  wire logic        SER_FOUR_WIRE,
  input  wire logic        SER_START,
  input  wire logic        SER_READ,
  input  wire logic [6:0]  SER_ADDR,
  input  wire logic [7:0]  SER_WDATA,
  output logic             SER_BUSY,
  output logic             SER_DONE,
  output logic [7:0]       SER_RDATA
);

  ddfe_pkg::ddfe_src_state_t s;
  ddfe_pkg::ddfe_src_state_t next_s;
  logic                      take;
  logic                      rd_pin;

  assign take   = SAMPLE_VALID & ~s.sending;
  // Read data arrives on the separate pin only in four-wire mode
  assign rd_pin = SER_FOUR_WIRE ? LINK.alarm_serial_out : LINK.serial_data_io;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    next_s.txen = TX_ENABLE;
    next_s.rstn = CHIP_RESET_N;
    // Byte 0 always leaves on a rising data clock edge since a frame is four toggles
    if (take) begin
      next_s.bus      = SAMPLE_A[15:8];
      next_s.rest     = {SAMPLE_A[7:0], SAMPLE_B};
      next_s.frame    = 1'b1;
      next_s.dclk     = ~s.dclk;
      next_s.sending  = 1'b1;
      next_s.byte_idx = 2'h1;
    end else if (s.sending) begin
      next_s.bus      = s.rest[23:16];
      next_s.rest     = {s.rest[15:0], 8'h00};
      next_s.frame    = 1'b0;
      next_s.dclk     = ~s.dclk;
      next_s.byte_idx = s.byte_idx + 2'h1;
      if (s.byte_idx == `DDFE_LAST_BYTE) begin
        next_s.sending = 1'b0;
      end
    end else begin
      next_s.frame = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    if (!s.ser_busy) begin
      if (SER_START) begin
        next_s.ser_busy = 1'b1;
        next_s.sen_n    = 1'b0;
        next_s.ser_sh   = {SER_READ, SER_ADDR, SER_WDATA};
        next_s.ser_rd   = SER_READ;
        next_s.ser_bit  = 5'h00;
        next_s.half     = 3'h0;
        next_s.sout     = SER_READ;
        next_s.soe      = 1'b1;
      end
    end else if (s.half != 3'(`DDFE_SCLK_HALF_CYC - 1)) begin
      next_s.half = s.half + 3'h1;
    end else begin
      next_s.half = 3'h0;
      if (!s.sclk) begin
        next_s.sclk = 1'b1;
        if (s.ser_rd && s.ser_bit >= `DDFE_SER_INSTR) begin
          next_s.rdata = {s.rdata[6:0], rd_pin};
        end
      end else begin
        next_s.sclk    = 1'b0;
        next_s.ser_bit = s.ser_bit + 5'h01;
        next_s.ser_sh  = {s.ser_sh[14:0], 1'b0};
        next_s.sout    = s.ser_sh[14];
        // Release the wire before the device turns it round
        next_s.soe     = ~(s.ser_rd && s.ser_bit >= `DDFE_SER_INSTR_LAST);
        if (s.ser_bit == `DDFE_SER_LAST) begin
          next_s.ser_busy = 1'b0;
          next_s.sen_n    = 1'b1;
          next_s.soe      = 1'b0;
          next_s.done     = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s       <= '0;
      s.sen_n <= 1'b1;
    end else if (CE) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign SAMPLE_READY         = ~s.sending;
  assign SER_BUSY             = s.ser_busy;
  assign SER_DONE             = s.done;
  assign SER_RDATA            = s.rdata;
  assign LINK.data_clock      = s.dclk;
  assign LINK.data_bus        = s.bus;
  assign LINK.frame_strobe    = s.frame;
  assign LINK.transmit_enable = s.txen;
  assign LINK.chip_reset_n    = s.rstn;
  assign LINK.serial_enable_n = s.sen_n;
  assign LINK.serial_clock    = s.sclk;
  assign LINK.sdio_src_out    = s.sout;
  assign LINK.sdio_src_oe     = s.soe;

endmodule : ddfe_source

`default_nettype wire

// >>> ddfe_device.sv
// Converter front end: DDR byte capture, frame alignment, sample FIFO, divider
// resync by output strobe, transmit gating and the serial control port.
// Assumes every link and user input is synchronous to CLK; edges of the data,
// converter and serial clocks are found by comparing with the previous sample.
`timescale 1ns/10ps
`default_nettype none

module ddfe_device (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        CE,
  ddfe_link_if.device      LINK,
  input  wire logic        CONV_CLK,
  input  wire logic        OUT_STROBE,
  output logic [15:0]      CHA_PRIMARY,
  output logic [15:0]      CHA_COMPL,
  output logic [15:0]      CHB_PRIMARY,
  output logic [15:0]      CHB_COMPL,
  output logic             SAMPLE_VALID,
  output logic             REF_INTERNAL_DRIVE,
  output logic [3:0]       FIFO_LEVEL
);

  ddfe_pkg::ddfe_dev_state_t s;
  ddfe_pkg::ddfe_dev_state_t next_s;
  logic                      rst;
  logic [7:0]                rev_bus;
  ddfe_pkg::ddfe_byte_t      byte_in;
  logic                      dclk_rise;
  logic                      dclk_edge;
  logic                      cclk_rise;
  logic                      conv_tick;
  logic                      sclk_rise;
  logic                      sclk_fall;
  logic [7:0]                instr;
  logic [15:0]               word;
  ddfe_pkg::ddfe_byte_t      reg_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Either reset source clears everything, FIFO and configuration alike
  assign rst = RESET | ~LINK.chip_reset_n;

  for (genvar i = 0; i < 8; i++) begin : g_rev
    assign rev_bus[i] = LINK.data_bus[7 - i];
  end

  // Default order keeps pin 7 as the MSB
  assign byte_in   = s.cfg[`DDFE_CFG_REVERSE] ? rev_bus : LINK.data_bus;
  assign dclk_rise = LINK.data_clock & ~s.dclk_prev;
  assign dclk_edge = LINK.data_clock ^ s.dclk_prev;
  assign cclk_rise = CONV_CLK & ~s.cclk_prev;
  assign conv_tick = cclk_rise & ~OUT_STROBE & (s.div == `DDFE_CONV_DIV_LAST);
  assign sclk_rise = LINK.serial_clock & ~s.sclk_prev;
  assign sclk_fall = ~LINK.serial_clock & s.sclk_prev;
  assign instr     = {s.ser_in[6:0], LINK.serial_data_io};
  assign word      = {s.ser_in, LINK.serial_data_io};

  always_comb begin
    if (instr[6:0] == `DDFE_REG_CFG) begin
      reg_rdata = s.cfg;
    end else if (instr[6:0] == `DDFE_REG_STAT) begin
      reg_rdata = {s.alarm, 3'h0, s.count};
    end else begin
      reg_rdata = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic pop;
    logic push;
    logic realign;
    pop              = 1'b0;
    push             = 1'b0;
    realign          = 1'b0;
    next_s           = s;
    next_s.dclk_prev = LINK.data_clock;
    next_s.cclk_prev = CONV_CLK;
    next_s.sclk_prev = LINK.serial_clock;
    next_s.out_valid = 1'b0;

    // Divider restarts so that several devices share one read phase
    if (cclk_rise) begin
      if (OUT_STROBE) begin
        next_s.div = 1'b0;
      end else begin
        next_s.div = s.div + 1'b1;
      end
    end

    if (!LINK.transmit_enable) begin
      // Bytes are dropped and the outputs sit at code zero
      next_s.aligned  = 1'b0;
      next_s.byte_idx = 2'h0;
      next_s.frag     = 24'h000000;
      next_s.wr_ptr   = '0;
      next_s.rd_ptr   = '0;
      next_s.count    = '0;
      next_s.out_a    = 16'h0000;
      next_s.out_b    = 16'h0000;
    end else begin
      // Read side; an empty FIFO at a read slot once aligned is an underrun
      if (conv_tick && s.count != '0) begin
        pop              = 1'b1;
        next_s.out_a     = s.mem[s.rd_ptr][31:16];
        next_s.out_b     = s.mem[s.rd_ptr][15:0];
        next_s.out_valid = 1'b1;
        next_s.rd_ptr    = s.rd_ptr + 3'h1;
      end
      if (dclk_rise && LINK.frame_strobe) begin
        // Frame start wins over byte capture; a read in the same cycle still outputs its sample
        realign         = 1'b1;
        next_s.aligned  = 1'b1;
        next_s.byte_idx = 2'h1;
        next_s.frag     = {16'h0000, byte_in};
        next_s.wr_ptr   = '0;
        next_s.rd_ptr   = '0;
        next_s.count    = '0;
      end else if (dclk_edge && s.aligned) begin
        next_s.frag     = {s.frag[15:0], byte_in};
        next_s.byte_idx = s.byte_idx + 2'h1;
        if (s.byte_idx == `DDFE_LAST_BYTE && (s.count != `DDFE_FIFO_FULL || pop)) begin
          push                 = 1'b1;
          next_s.mem[s.wr_ptr] = {s.frag, byte_in};
          next_s.wr_ptr        = s.wr_ptr + 3'h1;
        end
      end
      if (!realign) begin
        next_s.count = s.count + {3'h0, push} - {3'h0, pop};
      end
    end

    ////////////////////////////////////////////////////////////////////////////////
    if (LINK.serial_enable_n) begin
      // Idle port: bit count restarts and the wire is released
      next_s.ser_cnt = 5'h00;
      next_s.ser_rd  = 1'b0;
      next_s.sdo_en  = 1'b0;
    end else begin
      if (sclk_rise && s.ser_cnt < `DDFE_SER_BITS) begin
        next_s.ser_in  = word[14:0];
        next_s.ser_cnt = s.ser_cnt + 5'h01;
        if (s.ser_cnt == `DDFE_SER_INSTR_LAST) begin
          next_s.ser_rd  = instr[7];
          next_s.ser_out = reg_rdata;
        end
        if (s.ser_cnt == `DDFE_SER_LAST && !s.ser_rd) begin
          if (word[14:8] == `DDFE_REG_CFG) begin
            next_s.cfg = word[7:0];
          end else if (word[14:8] == `DDFE_REG_STAT && word[`DDFE_STAT_ALARM]) begin
            next_s.alarm = 1'b0;
          end
        end
      end
      // Read data changes on the falling edge, host samples on the rising one
      if (sclk_fall && s.ser_rd && s.ser_cnt >= `DDFE_SER_INSTR
          && s.ser_cnt < `DDFE_SER_BITS) begin
        next_s.sdo     = s.ser_out[7];
        next_s.ser_out = {s.ser_out[6:0], 1'b0};
        next_s.sdo_en  = 1'b1;
      end
    end

    // Set after clear so a fault in the clearing cycle is kept
    if (LINK.transmit_enable && s.aligned && conv_tick && s.count == '0) begin
      next_s.alarm = 1'b1;
    end
    if (LINK.transmit_enable && dclk_edge && s.aligned && !realign
        && s.byte_idx == `DDFE_LAST_BYTE && !push) begin
      next_s.alarm = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (rst) begin
      s     <= '0;
      s.cfg <= `DDFE_CFG_RESET;
    end else if (CE) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Primary sink grows as the code falls; complementary follows the code
  assign CHA_PRIMARY        = ~s.out_a;
  assign CHA_COMPL          = s.out_a;
  assign CHB_PRIMARY        = ~s.out_b;
  assign CHB_COMPL          = s.out_b;
  assign SAMPLE_VALID       = s.out_valid;
  assign FIFO_LEVEL         = s.count;
  // High: pin drives internal reference; low: pin is an external input
  assign REF_INTERNAL_DRIVE = ~s.cfg[`DDFE_CFG_EXTREF];

  // Alarm pin is active low unless it carries read data
  assign LINK.alarm_serial_out = s.cfg[`DDFE_CFG_FOUR_WIRE] ? (s.sdo_en & s.sdo)
                                                            : ~s.alarm;
  assign LINK.sdio_dev_out     = s.sdo;
  assign LINK.sdio_dev_oe      = s.sdo_en & ~s.cfg[`DDFE_CFG_FOUR_WIRE];

endmodule : ddfe_device

`default_nettype wire

// >>> ddfe_link_monitor.sv
// Checker of the link between the data source and the converter front end.
// Assumes instantiation beside the link interface, on the common clock.
`timescale 1ns/10ps
`default_nettype none

module ddfe_link_monitor (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic data_clock,
  input wire logic frame_strobe,
  input wire logic serial_enable_n,
  input wire logic serial_clock,
  input wire logic sdio_dev_oe,
  input wire logic sdio_src_oe
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  ////////////////////////////////////////////////////////////////////////////////
  // Byte bus framing
  a_frame_rising: assert property (frame_strobe |-> data_clock && $changed(data_clock))
    else $error("frame strobe not on a rising data clock");
  a_frame_single: assert property (frame_strobe |=> !frame_strobe)
    else $error("frame strobe longer than one byte");
  a_four_bytes: assert property (frame_strobe |=> ($changed(data_clock) && !frame_strobe)[*3])
    else $error("frame not followed by three more byte edges");
  // Idle clock stands still, so a stray edge would be a phantom byte
  a_clock_framed: assert property ($changed(data_clock) |-> frame_strobe ||
    $past(frame_strobe) || $past(frame_strobe, 2) || $past(frame_strobe, 3))
    else $error("data clock edge outside a frame");

  ////////////////////////////////////////////////////////////////////////////////
  // Serial control port
  a_serial_span: assert property ($fell(serial_enable_n) |-> ##64 $rose(serial_enable_n))
    else $error("serial transaction not 64 cycles long");
  a_sclk_idle_low: assert property (serial_enable_n |-> !serial_clock)
    else $error("serial clock high while disabled");
  a_sdio_single: assert property (!(sdio_dev_oe && sdio_src_oe))
    else $error("both ends drive serial data");
  a_dev_quiet: assert property (serial_enable_n && $past(serial_enable_n) |-> !sdio_dev_oe)
    else $error("device drives serial data while disabled");

  c_frame: cover property (frame_strobe);
  c_serial: cover property ($fell(serial_enable_n));
  c_dev_drive: cover property (sdio_dev_oe);
endmodule : ddfe_link_monitor

`default_nettype wire

// >>> dual_dac_ddr_input_front_end_tb.sv
// Bench of the front end: source and device joined by the link, random sample pairs.
// Assumes the package, link interface, both ends and the link monitor compile first.
`timescale 1ns/10ps
`default_nettype none

module dual_dac_ddr_input_front_end_tb;
  logic        clk, reset, conv_clk, out_strobe, sample_valid, sample_ready;
  logic        tx_enable, chip_reset_n, ser_four_wire, ser_start, ser_read;
  logic        ser_busy, ser_done, out_valid, ref_int, got, g2, ce;
  logic [6:0]  ser_addr;
  logic [7:0]  ser_wdata, ser_rdata;
  logic [15:0] sample_a, sample_b, cha_p, cha_c, chb_p, chb_c;
  logic [3:0]  fifo_level;
  logic [31:0] w;
  int          num_errors = 0;
  int          checks_done = 0;
  int          seed = 35284;

  ddfe_link_if ddfe_link_if_inst ();
  ddfe_source ddfe_source_inst (.CLK(clk), .RESET(reset), .CE(ce), .LINK(ddfe_link_if_inst),
    .SAMPLE_A(sample_a), .SAMPLE_B(sample_b), .SAMPLE_VALID(sample_valid),
    .SAMPLE_READY(sample_ready), .TX_ENABLE(tx_enable), .CHIP_RESET_N(chip_reset_n),
    .SER_FOUR_WIRE(ser_four_wire), .SER_START(ser_start), .SER_READ(ser_read),
    .SER_ADDR(ser_addr), .SER_WDATA(ser_wdata), .SER_BUSY(ser_busy), .SER_DONE(ser_done),
    .SER_RDATA(ser_rdata));
  ddfe_device ddfe_device_inst (.CLK(clk), .RESET(reset), .CE(ce), .LINK(ddfe_link_if_inst),
    .CONV_CLK(conv_clk), .OUT_STROBE(out_strobe), .CHA_PRIMARY(cha_p), .CHA_COMPL(cha_c),
    .CHB_PRIMARY(chb_p), .CHB_COMPL(chb_c), .SAMPLE_VALID(out_valid),
    .REF_INTERNAL_DRIVE(ref_int), .FIFO_LEVEL(fifo_level));
  ddfe_link_monitor ddfe_link_monitor_inst (.CLK(clk), .RESET(reset),
    .data_clock(ddfe_link_if_inst.data_clock), .frame_strobe(ddfe_link_if_inst.frame_strobe),
    .serial_enable_n(ddfe_link_if_inst.serial_enable_n),
    .serial_clock(ddfe_link_if_inst.serial_clock),
    .sdio_dev_oe(ddfe_link_if_inst.sdio_dev_oe), .sdio_src_oe(ddfe_link_if_inst.sdio_src_oe));

  ////////////////////////////////////////////////////////////////////////////////
  // Checking and expectations
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Bit order flipped within each byte
  function automatic logic [31:0] flip(input logic [31:0] v, input logic rev);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = rev ? v[(i / 8) * 8 + 7 - i % 8] : v[i];
    return r;
  endfunction : flip

  ////////////////////////////////////////////////////////////////////////////////
  // Drivers, all entered at a falling edge
  task automatic send_pair(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] p;
    int          k;
    p = {a, b};
    sample_a = a;
    sample_b = b;
    sample_valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    sample_valid = 1'b0;
    k = 0;
    while (ddfe_link_if_inst.frame_strobe !== 1'b1 && k < 4) begin
      @(negedge clk);
      k++;
    end
    for (k = 0; k < 4; k++) begin
      check(32'(ddfe_link_if_inst.data_bus), 32'(p[31 - 8 * k -: 8]));
      check(32'(ddfe_link_if_inst.data_clock), 32'(k % 2 == 0));
      check(32'(sample_ready), 32'(k == 3));
      @(negedge clk);
    end
    repeat (3) @(negedge clk);
  endtask : send_pair

  task automatic conv_rise(input logic strobe, output logic seen);
    seen = 1'b0;
    conv_clk = 1'b1;
    out_strobe = strobe;
    // Valid pulse stands one cycle right after the rise, so look from the first edge on
    repeat (3) begin
      @(negedge clk);
      conv_clk = 1'b0;
      out_strobe = 1'b0;
      if (out_valid === 1'b1) seen = 1'b1;
    end
  endtask : conv_rise

  task automatic read_check(input logic [31:0] v, input logic rev, input int n);
    logic s;
    s = 1'b0;
    for (int i = 0; i < n && !s; i++) conv_rise(1'b0, s);
    check(32'(s), 32'h1);
    check({cha_c, chb_c}, flip(v, rev));
    check({cha_p, chb_p}, ~flip(v, rev));
    check(32'(fifo_level), 32'h0);
  endtask : read_check

  // Serial access; too long a wait counts as a mismatch
  task automatic ser(input logic rd, input logic [6:0] addr, input logic [7:0] wd);
    int n;
    ser_start = 1'b1;
    ser_read = rd;
    ser_addr = addr;
    ser_wdata = wd;
    @(negedge clk);
    ser_start = 1'b0;
    check(32'(ser_busy), 32'h1);
    n = 0;
    while (ser_done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(32'(n < 200), 32'h1);
    repeat (2) @(negedge clk);
  endtask : ser

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Whole run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end

  initial begin
    {reset, tx_enable, chip_reset_n, ce} = 4'hf;
    {conv_clk, out_strobe, sample_valid, ser_four_wire, ser_start, ser_read} = 6'h00;
    {sample_a, sample_b, ser_addr, ser_wdata} = '0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    check({cha_p, chb_p}, 32'hffffffff);
    check({cha_c, chb_c}, 32'h0);
    check(32'({fifo_level, ref_int}), 32'h1);
    for (int i = 0; i < 20; i++) begin
      w = (i == 0) ? 32'h0000ffff : (i == 1) ? 32'hffff0000 : $random(seed);
      if (i % 4 == 2) send_pair(~w[31:16], 16'h1234);
      send_pair(w[31:16], w[15:0]);
      check(32'(fifo_level), 32'h1);
      if (i == 5) begin
        conv_rise(1'b1, got);
        conv_rise(1'b0, g2);
        check(32'(got | g2), 32'h0);
      end
      if (i == 7) begin
        // Frozen clock enable hides a read slot from the device
        ce = 1'b0;
        conv_rise(1'b0, got);
        conv_rise(1'b0, g2);
        ce = 1'b1;
        check(32'(got | g2), 32'h0);
        check(32'(fifo_level), 32'h1);
      end
      read_check(w, 1'b0, (i == 5) ? 1 : 3);
    end
    tx_enable = 1'b0;
    repeat (4) @(negedge clk);
    check({cha_c, chb_c}, 32'h0);
    check({cha_p, chb_p}, 32'hffffffff);
    send_pair(16'h5a5a, 16'ha5a5);
    check(32'(fifo_level), 32'h0);
    conv_rise(1'b0, got);
    conv_rise(1'b0, g2);
    check(32'(got | g2), 32'h0);
    tx_enable = 1'b1;
    repeat (4) @(negedge clk);
    send_pair(16'h8001, 16'h7ffe);
    read_check(32'h80017ffe, 1'b0, 3);
    // Read slot on an empty FIFO: underrun alarm, pin low in three-wire mode
    conv_rise(1'b0, got);
    conv_rise(1'b0, g2);
    check(32'(got | g2), 32'h0);
    check(32'(ddfe_link_if_inst.alarm_serial_out), 32'h0);
    ser(1'b1, 7'h01, 8'h00);
    check(32'(ser_rdata), 32'h80);
    ser(1'b0, 7'h01, 8'h80);
    check(32'(ddfe_link_if_inst.alarm_serial_out), 32'h1);
    ser(1'b0, 7'h00, 8'h06);
    check(32'(ref_int), 32'h0);
    ser(1'b1, 7'h00, 8'h00);
    check(32'(ser_rdata), 32'h06);
    w = $random(seed);
    send_pair(w[31:16], w[15:0]);
    read_check(w, 1'b1, 3);
    ser(1'b0, 7'h00, 8'h01);
    ser_four_wire = 1'b1;
    ser(1'b1, 7'h00, 8'h00);
    check(32'(ser_rdata), 32'h01);
    check(32'(ref_int), 32'h1);
    send_pair(16'h0f0f, 16'hf0f0);
    // Link copy of the chip reset lags by one cycle
    chip_reset_n = 1'b0;
    repeat (4) @(negedge clk);
    chip_reset_n = 1'b1;
    ser_four_wire = 1'b0;
    repeat (4) @(negedge clk);
    check(32'(fifo_level), 32'h0);
    check({cha_p, chb_p}, 32'hffffffff);
    ser(1'b1, 7'h00, 8'h00);
    check(32'(ser_rdata), 32'h00);
    final_report();
  end
endmodule : dual_dac_ddr_input_front_end_tb

`default_nettype wire
